// ### logic/ao_ctrl_pkg.sv
package ao_ctrl_pkg;
  localparam int NUM_CH = 4;
  localparam int CODE_W = 16;
  localparam int BLOCK_BYTES = 16;
  localparam int SYNC_STAGES = 2;
  // Device and identification bytes
  localparam logic [7:0] DEV_HEADER = 8'h02;
  localparam int DEV_CHANNEL_FAULT_BIT = 0;
  localparam int DEV_CHECK_ERROR_BIT = 1;
  localparam logic [7:0] IDENT_FIRST = 8'h42;
  localparam logic [7:0] IDENT_SECOND = 8'h01;
  // Channel triple
  localparam logic [7:0] CH_HEADER = 8'h80;
  localparam logic [7:0] CH_INDEX_BASE = 8'h80;
  localparam logic [7:0] CODE_LINE_BROKEN = 8'hA6;
  localparam logic [7:0] CODE_OUTPUT_FAULT = 8'hB2;
  localparam logic [7:0] CODE_RECOVERY = 8'hA0;
  localparam int DEV_BYTE_POS = 0;
  localparam int IDENT_BYTE_POS = 2;
  localparam int CH_BYTE_POS = 4;
  localparam int CH_BYTES = 3;
  // Reset values of downloaded parameters and of the DAC codes
  localparam logic [NUM_CH-1:0] FAULT_ACTION_RESET = 4'h0;
  localparam logic [CODE_W-1:0] FAULT_VALUE_RESET = 16'h0000;
  localparam logic [NUM_CH-1:0] DIAG_ENABLE_RESET = 4'h0;
  localparam logic [CODE_W-1:0] DAC_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_ENABLED = 2'b01,
    ST_FAULT = 2'b11
  } out_state_t;

  // Second byte of a channel triple, channel counted from zero
  function automatic logic [7:0] chIndexByte(input int ch);
    chIndexByte = CH_INDEX_BASE + 8'(ch);
  endfunction : chIndexByte
endpackage : ao_ctrl_pkg

// ### logic/ao_channel_diag.sv
module ao_channel_diag (
  input wire logic clock,
  input wire logic rst,
  input wire logic diagEnable,
  input wire logic lineBroken,
  input wire logic mismatch,
  output logic [7:0] codeByte,
  output logic faultActive,
  output logic changed
);
  logic [7:0] next_code;
  wire logic nowBroken;
  wire logic nowMismatch;

  // ****************************************
  // Fault classification
  // ****************************************
  // Diagnosis gated by enable
  assign nowBroken = diagEnable & lineBroken;
  assign nowMismatch = diagEnable & mismatch;
  // Two separate diagnoses
  // Broken line wins: a mismatch is meaningless without loop current
  assign next_code = nowBroken ? ao_ctrl_pkg::CODE_LINE_BROKEN :
                     nowMismatch ? ao_ctrl_pkg::CODE_OUTPUT_FAULT : ao_ctrl_pkg::CODE_RECOVERY;

  // ****************************************
  // Report on change only
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      codeByte <= ao_ctrl_pkg::CODE_RECOVERY;
      faultActive <= 1'b0;
      changed <= 1'b0;
    end else begin
      codeByte <= next_code;
      faultActive <= (next_code != ao_ctrl_pkg::CODE_RECOVERY);
      changed <= (next_code != codeByte);
    end
  end

  report_once_a: assert property (@(posedge clock) disable iff (rst)
    $stable(codeByte) |-> !changed)
    else $error("channel report without code change");

  code_change_a: assert property (@(posedge clock) disable iff (rst)
    (codeByte != $past(codeByte)) |-> changed)
    else $error("channel code change not reported");

  diag_gate_a: assert property (@(posedge clock) disable iff (rst)
    !$past(diagEnable) |-> (codeByte == ao_ctrl_pkg::CODE_RECOVERY))
    else $error("fault code while diagnosis disabled");
endmodule : ao_channel_diag

// ### logic/ao_output_enable_fault_diag.sv
// Contract
// - After power-up all outputs stay inactive until a controller output instruction.
// - Initial state keeps outputs off; communication loss there applies no fault values.
// - Controller instruction applied to outputs marks output as enabled.
// - Enabled module entering fault mode drives each channel per its fault setting.
// - Reset or re-insertion returns to initial state; next instruction re-enables.
// - Loss of communication enters fault mode and flashes run indicator.
// - Per-channel bit chooses hold-last or substitute code; default hold-last.
// - Substitute value of each channel defaults to zero output.
// - Fault settings per channel, changed only by complete parameter download.
// - Each channel reports line broken and output mismatch separately.
// - Diagnostic block: 2 device, 2 identification, 12 channel bytes.
// - Three bytes per channel, channels one to four in order.
// - Device bytes 0x02 then fault summary: channel bit0, check-data bit1.
// - Identification bytes are 0x42 then 0x01.
// - Channel triple: 0x80, 0x80 plus index, fault code A6/B2/A0.
// - Channel report sent once on fault and once on recovery.
// - Per-channel diagnosis enable defaults to disabled.
module ao_output_enable_fault_diag (
  input wire logic clock,
  input wire logic rst,
  input wire logic commOk,
  input wire logic outputStrobe,
  input wire logic [15:0] cmdCode0,
  input wire logic [15:0] cmdCode1,
  input wire logic [15:0] cmdCode2,
  input wire logic [15:0] cmdCode3,
  input wire logic paramLoad,
  input wire logic [3:0] paramFaultAction,
  input wire logic [15:0] paramFaultValue0,
  input wire logic [15:0] paramFaultValue1,
  input wire logic [15:0] paramFaultValue2,
  input wire logic [15:0] paramFaultValue3,
  input wire logic [3:0] paramDiagEnable,
  input wire logic checkDataError,
  input wire logic [3:0] lineBroken,
  input wire logic [3:0] mismatch,
  output logic outputActive,
  output logic faultMode,
  output logic runFlash,
  output logic [15:0] dacCode0,
  output logic [15:0] dacCode1,
  output logic [15:0] dacCode2,
  output logic [15:0] dacCode3,
  output logic [127:0] diagBlockBytes,
  output logic diagReport
);
  localparam int N = ao_ctrl_pkg::NUM_CH;
  localparam int W = ao_ctrl_pkg::CODE_W;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] commMeta;
  logic [N-1:0] brokenMeta;
  logic [N-1:0] brokenSync;
  logic [N-1:0] mismatchMeta;
  logic [N-1:0] mismatchSync;
  logic commOkSync;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      commMeta <= 2'h0;
      brokenMeta <= '0;
      brokenSync <= '0;
      mismatchMeta <= '0;
      mismatchSync <= '0;
    end else begin
      commMeta <= {commMeta[0], commOk};
      brokenMeta <= lineBroken;
      brokenSync <= brokenMeta;
      mismatchMeta <= mismatch;
      mismatchSync <= mismatchMeta;
    end
  end
  assign commOkSync = commMeta[1];

  wire logic commLost;
  assign commLost = !commOkSync;

  // ****************************************
  // Downloaded fault parameters
  // ****************************************
  logic [N-1:0] faultAction;
  logic [N-1:0] diagEnable;
  logic [W-1:0] faultValue [N];
  wire logic [W-1:0] paramValue [N];
  wire logic [W-1:0] cmdCode [N];
  assign paramValue[0] = paramFaultValue0;
  assign paramValue[1] = paramFaultValue1;
  assign paramValue[2] = paramFaultValue2;
  assign paramValue[3] = paramFaultValue3;
  assign cmdCode[0] = cmdCode0;
  assign cmdCode[1] = cmdCode1;
  assign cmdCode[2] = cmdCode2;
  assign cmdCode[3] = cmdCode3;

  // Settings are never changed mid-operation, only on a full download
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      faultAction <= ao_ctrl_pkg::FAULT_ACTION_RESET;
      diagEnable <= ao_ctrl_pkg::DIAG_ENABLE_RESET;
      for (int i = 0; i < N; i++) begin
        faultValue[i] <= ao_ctrl_pkg::FAULT_VALUE_RESET;
      end
    end else if (paramLoad) begin
      faultAction <= paramFaultAction;
      diagEnable <= paramDiagEnable;
      for (int i = 0; i < N; i++) begin
        faultValue[i] <= paramValue[i];
      end
    end
  end

  param_hold_a: assert property (@(posedge clock) disable iff (rst)
    !$past(paramLoad) |-> ($stable(faultAction) && $stable(diagEnable) && $stable(faultValue[0])))
    else $error("fault setting changed without download");
  subst_default_a: assert property (@(posedge clock) disable iff (rst)
    $past(rst) |-> (faultValue[0] == ao_ctrl_pkg::FAULT_VALUE_RESET && faultValue[1] == faultValue[0]
      && faultValue[2] == faultValue[0] && faultValue[3] == faultValue[0]))
    else $error("substitute value not zero after reset");

  // ****************************************
  // Output enable state machine
  // ****************************************
  ao_ctrl_pkg::out_state_t state;
  ao_ctrl_pkg::out_state_t next_state;
  logic [W-1:0] dac [N];
  logic [W-1:0] next_dac [N];
  // An instruction needs a live link; one arriving while lost is stale
  wire logic cmdTaken;
  assign cmdTaken = outputStrobe && !commLost;

  always_comb begin
    next_state = state;
    for (int i = 0; i < N; i++) begin
      next_dac[i] = dac[i];
    end
    case (state)
      ao_ctrl_pkg::ST_INIT: begin
        if (cmdTaken) begin
          next_state = ao_ctrl_pkg::ST_ENABLED;
        end
      end
      ao_ctrl_pkg::ST_ENABLED: begin
        if (commLost) begin
          next_state = ao_ctrl_pkg::ST_FAULT;
        end
      end
      ao_ctrl_pkg::ST_FAULT: begin
        if (cmdTaken) begin
          next_state = ao_ctrl_pkg::ST_ENABLED;
        end
      end
      default: begin
        next_state = ao_ctrl_pkg::ST_INIT;
      end
    endcase
    if (cmdTaken) begin
      for (int i = 0; i < N; i++) begin
        next_dac[i] = cmdCode[i];
      end
    end else if (state == ao_ctrl_pkg::ST_ENABLED && commLost) begin
      for (int i = 0; i < N; i++) begin
        next_dac[i] = faultAction[i] ? faultValue[i] : dac[i];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ao_ctrl_pkg::ST_INIT;
      for (int i = 0; i < N; i++) begin
        dac[i] <= ao_ctrl_pkg::DAC_RESET;
      end
    end else begin
      state <= next_state;
      for (int i = 0; i < N; i++) begin
        dac[i] <= next_dac[i];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outputActive <= 1'b0;
      faultMode <= 1'b0;
      runFlash <= 1'b0;
      dacCode0 <= ao_ctrl_pkg::DAC_RESET;
      dacCode1 <= ao_ctrl_pkg::DAC_RESET;
      dacCode2 <= ao_ctrl_pkg::DAC_RESET;
      dacCode3 <= ao_ctrl_pkg::DAC_RESET;
    end else begin
      outputActive <= (next_state != ao_ctrl_pkg::ST_INIT);
      faultMode <= (next_state == ao_ctrl_pkg::ST_FAULT);
      runFlash <= commLost;
      dacCode0 <= next_dac[0];
      dacCode1 <= next_dac[1];
      dacCode2 <= next_dac[2];
      dacCode3 <= next_dac[3];
    end
  end

  init_no_output_a: assert property (@(posedge clock) disable iff (rst)
    (state == ao_ctrl_pkg::ST_INIT) |-> (!outputActive && !faultMode))
    else $error("output active in initial state");

  init_holds_a: assert property (@(posedge clock) disable iff (rst)
    (state == ao_ctrl_pkg::ST_INIT && commLost) |=> (state == ao_ctrl_pkg::ST_INIT && !faultMode))
    else $error("fault mode applied before enable");
  enable_after_cmd_a: assert property (@(posedge clock) disable iff (rst)
    cmdTaken |=> (outputActive && dacCode0 == $past(cmdCode0) && dacCode3 == $past(cmdCode3)))
    else $error("instruction not applied or enable not set");
  fault_values_a: assert property (@(posedge clock) disable iff (rst)
    (state == ao_ctrl_pkg::ST_ENABLED && commLost && !outputStrobe) |=>
      (faultMode && dacCode0 == ($past(faultAction[0]) ? $past(faultValue[0]) : $past(dacCode0))))
    else $error("fault output value wrong");

  run_flash_a: assert property (@(posedge clock) disable iff (rst)
    $fell(commOkSync) |=> (runFlash [*1]))
    else $error("run indicator not flashing on link loss");

  // ****************************************
  // Channel diagnosis and block assembly
  // ****************************************
  logic [7:0] chCode [N];
  logic [N-1:0] chFault;
  logic [N-1:0] chChanged;

  for (genvar g = 0; g < N; g++) begin : gen_ch
    ao_channel_diag ao_channel_diag_i (
      .clock(clock),
      .rst(rst),
      .diagEnable(diagEnable[g]),
      .lineBroken(brokenSync[g]),
      .mismatch(mismatchSync[g]),
      .codeByte(chCode[g]),
      .faultActive(chFault[g]),
      .changed(chChanged[g])
    );
  end

  wire logic [7:0] devStatus;
  assign devStatus = {6'h00, checkDataError, |chFault};

  logic [127:0] next_block;
  always_comb begin
    next_block = '0;
    next_block[8*ao_ctrl_pkg::DEV_BYTE_POS +: 8] = ao_ctrl_pkg::DEV_HEADER;
    next_block[8*(ao_ctrl_pkg::DEV_BYTE_POS+1) +: 8] = devStatus;
    next_block[8*ao_ctrl_pkg::IDENT_BYTE_POS +: 8] = ao_ctrl_pkg::IDENT_FIRST;
    next_block[8*(ao_ctrl_pkg::IDENT_BYTE_POS+1) +: 8] = ao_ctrl_pkg::IDENT_SECOND;
    for (int i = 0; i < N; i++) begin
      next_block[8*(ao_ctrl_pkg::CH_BYTE_POS + ao_ctrl_pkg::CH_BYTES*i) +: 8] = ao_ctrl_pkg::CH_HEADER;
      next_block[8*(ao_ctrl_pkg::CH_BYTE_POS + ao_ctrl_pkg::CH_BYTES*i + 1) +: 8] = ao_ctrl_pkg::chIndexByte(i);
      next_block[8*(ao_ctrl_pkg::CH_BYTE_POS + ao_ctrl_pkg::CH_BYTES*i + 2) +: 8] = chCode[i];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      diagBlockBytes <= '0;
      diagReport <= 1'b0;
    end else begin
      diagBlockBytes <= next_block;
      diagReport <= |chChanged;
    end
  end

  block_layout_a: assert property (@(posedge clock) disable iff (rst)
    $past(!rst) |-> (diagBlockBytes[7:0] == 8'h02 && diagBlockBytes[31:16] == 16'h0142
      && diagBlockBytes[111:104] == 8'h80 && diagBlockBytes[119:112] == 8'h83))
    else $error("diagnostic block layout wrong");
  dev_summary_a: assert property (@(posedge clock) disable iff (rst)
    ($past(chFault) != 4'h0) |-> (diagBlockBytes[8] && diagBlockBytes[9] == $past(checkDataError)))
    else $error("device summary byte wrong");
  report_pulse_a: assert property (@(posedge clock) disable iff (rst)
    (chChanged == 4'h0) |=> !diagReport)
    else $error("diagnostic report without channel change");
endmodule : ao_output_enable_fault_diag

// ### sim/dp_controller_model.sv
module dp_controller_model (
  input wire logic clock,
  output logic commOk,
  output logic outputStrobe,
  output logic [15:0] cmdCode0,
  output logic [15:0] cmdCode1,
  output logic [15:0] cmdCode2,
  output logic [15:0] cmdCode3,
  output logic paramLoad,
  output logic [3:0] paramFaultAction,
  output logic [15:0] paramFaultValue0,
  output logic [15:0] paramFaultValue1,
  output logic [15:0] paramFaultValue2,
  output logic [15:0] paramFaultValue3,
  output logic [3:0] paramDiagEnable
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    commOk = 1'b1;
    outputStrobe = 1'b0;
    paramLoad = 1'b0;
    {cmdCode0, cmdCode1, cmdCode2, cmdCode3} = 64'h0;
    {paramFaultValue0, paramFaultValue1, paramFaultValue2, paramFaultValue3} = 64'h0;
    {paramFaultAction, paramDiagEnable} = 8'h00;
  end

  task automatic setLink(input logic up);
    @(posedge clock);
    commOk <= up;
  endtask : setLink

  task automatic sendCodes(input int lag, input logic [15:0] a, b, e, d);
    repeat (lag) @(posedge clock);
    @(posedge clock);
    outputStrobe <= 1'b1;
    {cmdCode3, cmdCode2, cmdCode1, cmdCode0} <= {d, e, b, a};
    @(posedge clock);
    outputStrobe <= 1'b0;
    // Stale codes are inverted so a late capture shows up
    {cmdCode3, cmdCode2, cmdCode1, cmdCode0} <= ~{d, e, b, a};
  endtask : sendCodes

  task automatic download(input logic [3:0] act, input logic [15:0] f0, f1, f2, f3, input logic [3:0] en);
    @(posedge clock);
    paramLoad <= 1'b1;
    {paramFaultAction, paramDiagEnable} <= {act, en};
    {paramFaultValue3, paramFaultValue2, paramFaultValue1, paramFaultValue0} <= {f3, f2, f1, f0};
    @(posedge clock);
    paramLoad <= 1'b0;
    {paramFaultAction, paramDiagEnable} <= ~{act, en};
    {paramFaultValue3, paramFaultValue2, paramFaultValue1, paramFaultValue0} <= ~{f3, f2, f1, f0};
  endtask : download
endmodule : dp_controller_model

// ### sim/ao_output_enable_fault_diag_bench.sv
module ao_output_enable_fault_diag_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst, checkDataError, commOk, outputStrobe, paramLoad;
  logic outputActive, faultMode, runFlash, diagReport;
  logic [3:0] lineBroken, mismatch, paramFaultAction, paramDiagEnable;
  logic [15:0] cmdCode0, cmdCode1, cmdCode2, cmdCode3, dacCode0, dacCode1, dacCode2, dacCode3;
  logic [15:0] paramFaultValue0, paramFaultValue1, paramFaultValue2, paramFaultValue3;
  logic [127:0] diagBlockBytes;
  logic [127:0] notes[$];
  logic [7:0] chCode[4];
  logic [15:0] c[4];
  logic [15:0] v[4];
  int bad_count, checks_done, seed;

  ao_output_enable_fault_diag ao_output_enable_fault_diag_i (.clock, .rst, .commOk, .outputStrobe, .cmdCode0,
    .cmdCode1, .cmdCode2, .cmdCode3, .paramLoad, .paramFaultAction, .paramFaultValue0, .paramFaultValue1,
    .paramFaultValue2, .paramFaultValue3, .paramDiagEnable, .checkDataError, .lineBroken, .mismatch,
    .outputActive, .faultMode, .runFlash, .dacCode0, .dacCode1, .dacCode2, .dacCode3, .diagBlockBytes, .diagReport);
  dp_controller_model dp_controller_model_i (.clock, .commOk, .outputStrobe, .cmdCode0, .cmdCode1, .cmdCode2,
    .cmdCode3, .paramLoad, .paramFaultAction, .paramFaultValue0, .paramFaultValue1, .paramFaultValue2,
    .paramFaultValue3, .paramDiagEnable);

  // ********************
  // Checking helpers
  // ********************
  task automatic check(input logic [127:0] seen, input logic [127:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic checkOut(input logic [2:0] st, input logic [15:0] d0, d1, d2, d3);
    check(128'({outputActive, faultMode, runFlash, dacCode3, dacCode2, dacCode1, dacCode0}),
      128'({st, d3, d2, d1, d0}));
  endtask : checkOut

  function automatic logic [127:0] expBlock();
    logic [127:0] b;
    logic anyFault;
    anyFault = 1'b0;
    b = {96'h0, 8'h01, 8'h42, 8'h00, 8'h02};
    for (int i = 0; i < 4; i++) begin
      anyFault = anyFault | (chCode[i] != 8'hA0);
      b[32 + 24 * i +: 24] = {chCode[i], 8'h80 + 8'(i), 8'h80};
    end
    b[9:8] = {checkDataError, anyFault};
    return b;
  endfunction : expBlock

  // Waits out sync, code and block stages before the next change
  task automatic setDiag(input int ch, input logic br, input logic mm, input logic [7:0] code, input logic rep);
    @(posedge clock);
    lineBroken[ch] <= br;
    mismatch[ch] <= mm;
    if (rep) begin
      chCode[ch] = code;
      notes.push_back(expBlock());
    end
    repeat (6) @(posedge clock);
  endtask : setDiag

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    if (diagReport === 1'b1) begin
      check(diagBlockBytes, (notes.size() > 0) ? notes.pop_front() : 'x);
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    results();
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    seed = 22;
    rst = 1'b1;
    checkDataError = 1'b0;
    lineBroken = 4'h0;
    mismatch = 4'h0;
    chCode = '{8'hA0, 8'hA0, 8'hA0, 8'hA0};
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    checkOut(3'b000, 16'h0, 16'h0, 16'h0, 16'h0);
    check(diagBlockBytes, expBlock());
    $display("test reset done");
    dp_controller_model_i.setLink(1'b0);
    repeat (5) @(posedge clock);
    dp_controller_model_i.sendCodes(0, 16'h1111, 16'h2222, 16'h3333, 16'h4444);
    repeat (3) @(posedge clock);
    checkOut(3'b001, 16'h0, 16'h0, 16'h0, 16'h0);
    dp_controller_model_i.setLink(1'b1);
    repeat (6) @(posedge clock);
    checkOut(3'b000, 16'h0, 16'h0, 16'h0, 16'h0);
    setDiag(0, 1'b1, 1'b1, 8'hA6, 1'b0);
    check(diagBlockBytes, expBlock());
    setDiag(0, 1'b0, 1'b0, 8'hA0, 1'b0);
    $display("test initial state done");
    for (int i = 0; i < 4; i++) begin
      v[i] = 16'($random(seed));
    end
    dp_controller_model_i.download(4'h5, v[0], v[1], v[2], v[3], 4'hF);
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 4; i++) begin
        c[i] = 16'($random(seed));
      end
      dp_controller_model_i.sendCodes(3 * k, c[0], c[1], c[2], c[3]);
    end
    repeat (3) @(posedge clock);
    checkOut(3'b100, c[0], c[1], c[2], c[3]);
    dp_controller_model_i.setLink(1'b0);
    repeat (5) @(posedge clock);
    checkOut(3'b111, v[0], c[1], v[2], c[3]);
    dp_controller_model_i.setLink(1'b1);
    repeat (5) @(posedge clock);
    dp_controller_model_i.sendCodes(0, c[3], c[2], c[1], c[0]);
    repeat (5) @(posedge clock);
    checkOut(3'b100, c[3], c[2], c[1], c[0]);
    $display("test fault mode done");
    for (int i = 0; i < 4; i++) begin
      setDiag(i, 1'b1, 1'b0, 8'hA6, 1'b1);
      setDiag(i, 1'b1, 1'b1, 8'hA6, 1'b0);
      setDiag(i, 1'b0, 1'b1, 8'hB2, 1'b1);
      setDiag(i, 1'b0, 1'b0, 8'hA0, 1'b1);
    end
    @(posedge clock);
    checkDataError <= 1'b1;
    repeat (4) @(posedge clock);
    check(diagBlockBytes, expBlock());
    setDiag(3, 1'b1, 1'b0, 8'hA6, 1'b1);
    setDiag(3, 1'b0, 1'b0, 8'hA0, 1'b1);
    checkDataError <= 1'b0;
    check(128'(notes.size()), 128'h0);
    $display("test diagnosis done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    checkOut(3'b000, 16'h0, 16'h0, 16'h0, 16'h0);
    dp_controller_model_i.sendCodes(1, c[0], c[1], c[2], c[3]);
    dp_controller_model_i.setLink(1'b0);
    repeat (5) @(posedge clock);
    checkOut(3'b111, c[0], c[1], c[2], c[3]);
    $display("test second reset done");
    results();
  end
endmodule : ao_output_enable_fault_diag_bench
